// ==== io_pkg.sv ====
package io_pkg;
  // Stream buffer shape
  localparam int unsigned FIFO_W     = 4;
  localparam int unsigned FIFO_DEPTH = 16;
  // Word field positions (gearbox: a0, a1, b0, b1)
  localparam int unsigned BIT_NEG0   = 0;
  localparam int unsigned BIT_POS0   = 1;
  localparam int unsigned BIT_NEG1   = 2;
  localparam int unsigned BIT_POS1   = 3;
  // Strobe transfer delay phase
  localparam int unsigned PHASE_DEG  = 90;
  localparam int unsigned HALF_DEG   = 180;
  localparam int unsigned FULL_DEG   = 360;
  localparam int unsigned CNT_W      = 8;
  localparam logic [7:0]  CNT_MAX    = 8'hff;
  localparam logic [7:0]  CNT_ONE    = 8'h01;
  localparam logic [1:0]  PHASE_LAST = 2'h3;

  typedef enum logic [1:0] {
    MODE_SDR  = 2'b00,
    MODE_DDR  = 2'b01,
    MODE_GEAR = 2'b10
  } out_mode_t;

  typedef enum logic [1:0] {
    POL_IDLE  = 2'b00,
    POL_ARMED = 2'b01,
    POL_BURST = 2'b10
  } pol_state_t;
endpackage

// ==== stream_fifo.sv ====
module stream_fifo #(
  parameter int unsigned W     = io_pkg::FIFO_W,
  parameter int unsigned DEPTH = io_pkg::FIFO_DEPTH
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic      [W-1:0] out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wptr;
    logic [AW-1:0]           rptr;
    logic [AW:0]             count;
  } fifo_state_t;

  fifo_state_t s_ff;
  fifo_state_t nxt_s;
  logic        push;
  logic        pop;

  assign in_ready  = (s_ff.count != (AW+1)'(DEPTH));
  assign out_valid = (s_ff.count != '0);
  assign out_data  = s_ff.mem[s_ff.rptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    nxt_s = s_ff;
    if (push) begin
      nxt_s.mem[s_ff.wptr] = in_data;
      nxt_s.wptr           = AW'(s_ff.wptr + 1'b1);
    end
    if (pop) begin
      nxt_s.rptr = AW'(s_ff.rptr + 1'b1);
    end
    if (push && !pop) begin
      nxt_s.count = (AW+1)'(s_ff.count + 1'b1);
    end else if (pop && !push) begin
      nxt_s.count = (AW+1)'(s_ff.count - 1'b1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule

// ==== io_cell_pair.sv ====
module io_cell_pair #(
  parameter bit LVDS_CAPABLE = 1'b1
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] out_mode,
  input  wire logic       sdr_latch,
  input  wire logic       diff_pair,
  input  wire logic [3:0] in_data,
  input  wire logic       in_valid,
  output logic            in_ready,
  input  wire logic [1:0] oe_req,
  input  wire logic       edge_clock_one,
  output logic      [1:0] pad_out,
  output logic      [1:0] pad_tristate_control,
  input  wire logic [1:0] pad_in,
  output logic      [1:0] cell_in,
  input  wire logic       read_start,
  input  wire logic       read_end,
  input  wire logic       strobe_in,
  output logic            sync_clock_polarity,
  output logic            read_active,
  output logic      [1:0] rd_data,
  output logic            rd_valid,
  output logic            strobe_transfer_delay
);
  typedef struct packed {
    logic                ec_s1;
    logic                ec_s2;
    logic                ec_d;
    logic                st_s1;
    logic                st_s2;
    logic                st_d;
    logic [1:0]          pad_s1;
    logic [1:0]          pad_s2;
    logic [3:0]          hold;
    logic [1:0]          phase;
    logic [1:0]          pad;
    logic [1:0]          oe;
    logic [7:0]          cnt;
    logic [7:0]          period;
    logic                shift;
    io_pkg::pol_state_t  st;
    logic                pol;
    logic [1:0]          rdata;
    logic                rvalid;
  } cell_state_t;

  cell_state_t s_ff;
  cell_state_t nxt_s;
  logic [3:0]  head;
  logic        head_valid;
  logic        pop;
  logic        ec_rise;
  logic        ec_fall;
  logic        st_rise;
  logic        st_fall;
  logic        comp_on;

  function automatic logic rise(input logic cur, input logic prev);
    return cur && !prev;
  endfunction

  function automatic logic [7:0] phase_at(input logic [7:0] per, input int unsigned deg);
    logic [15:0] p;
    p = (16'(per) * 16'(deg)) / 16'(io_pkg::FULL_DEG);
    return p[7:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Output data buffer
  stream_fifo #(
    .W     (io_pkg::FIFO_W),
    .DEPTH (io_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_data   (in_data),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .out_data  (head),
    .out_valid (head_valid),
    .out_ready (pop)
  );

  assign ec_rise = rise(s_ff.ec_s2, s_ff.ec_d);
  assign ec_fall = rise(s_ff.ec_d, s_ff.ec_s2);
  assign st_rise = rise(s_ff.st_s2, s_ff.st_d);
  assign st_fall = rise(s_ff.st_d, s_ff.st_s2);
  assign comp_on = LVDS_CAPABLE && (diff_pair || out_mode == io_pkg::MODE_GEAR);

  always_comb begin
    pop = 1'b0;
    case (io_pkg::out_mode_t'(out_mode))
      io_pkg::MODE_SDR:  pop = head_valid && (sdr_latch ? ec_fall : ec_rise);
      io_pkg::MODE_DDR:  pop = head_valid && ec_rise;
      io_pkg::MODE_GEAR: pop = head_valid && ec_rise && (s_ff.phase == '0);
      default:           pop = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_s        = s_ff;
    nxt_s.ec_s1  = edge_clock_one;
    nxt_s.ec_s2  = s_ff.ec_s1;
    nxt_s.ec_d   = s_ff.ec_s2;
    nxt_s.st_s1  = strobe_in;
    nxt_s.st_s2  = s_ff.st_s1;
    nxt_s.st_d   = s_ff.st_s2;
    nxt_s.pad_s1 = pad_in;
    nxt_s.pad_s2 = s_ff.pad_s1;
    nxt_s.rvalid = 1'b0;

    case (io_pkg::out_mode_t'(out_mode))
      io_pkg::MODE_SDR: begin
        if (sdr_latch ? (s_ff.ec_s2 && head_valid) : pop) begin
          nxt_s.pad[0] = head[io_pkg::BIT_NEG0];
          nxt_s.pad[1] = head[io_pkg::BIT_NEG1];
        end
      end
      io_pkg::MODE_DDR: begin
        if (pop) begin
          nxt_s.hold   = head;
          nxt_s.pad[0] = head[io_pkg::BIT_NEG0];
          nxt_s.pad[1] = head[io_pkg::BIT_NEG1];
        end
        if (ec_fall) begin
          nxt_s.pad[0] = s_ff.hold[io_pkg::BIT_POS0];
          nxt_s.pad[1] = s_ff.hold[io_pkg::BIT_POS1];
        end
      end
      io_pkg::MODE_GEAR: begin
        if (pop) begin
          nxt_s.hold   = head;
          nxt_s.pad[0] = head[io_pkg::BIT_NEG0];
          nxt_s.phase  = 2'h1;
        end else if ((ec_rise || ec_fall) && s_ff.phase != '0) begin
          nxt_s.pad[0] = s_ff.hold[s_ff.phase];
          nxt_s.phase  = (s_ff.phase == io_pkg::PHASE_LAST) ? 2'h0 : 2'(s_ff.phase + 1'b1);
        end
      end
      default: begin
        nxt_s.pad = s_ff.pad;
      end
    endcase
    if (comp_on) begin
      nxt_s.pad[1] = ~nxt_s.pad[0];
    end

    if (ec_rise) begin
      nxt_s.oe = comp_on ? {oe_req[0], oe_req[0]} : oe_req;
    end

    if (ec_rise) begin
      nxt_s.cnt    = '0;
      nxt_s.period = (s_ff.cnt == io_pkg::CNT_MAX) ? io_pkg::CNT_MAX : 8'(s_ff.cnt + io_pkg::CNT_ONE);
    end else if (s_ff.cnt != io_pkg::CNT_MAX) begin
      nxt_s.cnt = 8'(s_ff.cnt + io_pkg::CNT_ONE);
    end
    if (s_ff.cnt == phase_at(s_ff.period, io_pkg::PHASE_DEG)) begin
      nxt_s.shift = 1'b1;
    end else if (s_ff.cnt == phase_at(s_ff.period, io_pkg::PHASE_DEG + io_pkg::HALF_DEG)) begin
      nxt_s.shift = 1'b0;
    end

    case (s_ff.st)
      io_pkg::POL_IDLE: begin
        if (read_start) begin
          nxt_s.st = io_pkg::POL_ARMED;
        end
      end
      io_pkg::POL_ARMED: begin
        if (st_fall) begin
          nxt_s.st  = io_pkg::POL_BURST;
          nxt_s.pol = s_ff.ec_s2;
        end else if (read_end) begin
          nxt_s.st = io_pkg::POL_IDLE;
        end
      end
      io_pkg::POL_BURST: begin
        if (s_ff.pol ? st_fall : st_rise) begin
          nxt_s.rdata  = s_ff.pad_s2;
          nxt_s.rvalid = 1'b1;
        end
        if (read_end) begin
          nxt_s.st = io_pkg::POL_IDLE;
        end
      end
      default: begin
        nxt_s.st = io_pkg::POL_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign pad_out               = s_ff.pad;
  assign pad_tristate_control  = s_ff.oe;
  assign cell_in               = s_ff.pad_s2;
  assign sync_clock_polarity   = s_ff.pol;
  assign read_active           = (s_ff.st == io_pkg::POL_BURST);
  assign rd_data               = s_ff.rdata;
  assign rd_valid              = s_ff.rvalid;
  assign strobe_transfer_delay = s_ff.shift;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence seq_preamble;
    (s_ff.st == io_pkg::POL_ARMED) && st_fall;
  endsequence

  sequence seq_ddr_rise;
    (out_mode == io_pkg::MODE_DDR) && pop;
  endsequence

  sequence seq_ddr_fall;
    (out_mode == io_pkg::MODE_DDR) && ec_fall;
  endsequence

  sequence seq_in_burst;
    (s_ff.st == io_pkg::POL_BURST) && !read_end;
  endsequence

  AST_PREAMBLE_POL: assert property (@(posedge core_clk) disable iff (!rst_n)
    seq_preamble |=> read_active && (sync_clock_polarity == $past(s_ff.ec_s2)))
    else $error("Polarity not set at preamble");

  AST_POL_HELD: assert property (@(posedge core_clk) disable iff (!rst_n)
    seq_in_burst |=> $stable(sync_clock_polarity))
    else $error("Polarity changed mid burst");

  AST_READ_ARM: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_ff.st == io_pkg::POL_IDLE) && read_start |=> (s_ff.st == io_pkg::POL_ARMED))
    else $error("Read start did not arm detector");

  AST_CAPTURE_EDGE: assert property (@(posedge core_clk) disable iff (!rst_n)
    seq_in_burst ##0 (sync_clock_polarity ? st_fall : st_rise) |=> rd_valid && rd_data == $past(cell_in))
    else $error("Read data not captured on selected edge");

  AST_DDR_NEG: assert property (@(posedge core_clk) disable iff (!rst_n)
    seq_ddr_rise |=> pad_out[0] == $past(head[io_pkg::BIT_NEG0]))
    else $error("Double rate negative path not driven");

  AST_DDR_POS: assert property (@(posedge core_clk) disable iff (!rst_n)
    seq_ddr_fall |=> pad_out[0] == $past(s_ff.hold[io_pkg::BIT_POS0]))
    else $error("Double rate positive path not driven");

  AST_SDR_FF_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    (out_mode == io_pkg::MODE_SDR) && !sdr_latch && !pop |=> $stable(pad_out[0]))
    else $error("Flip-flop output moved without edge");

  AST_COMP_PAIR: assert property (@(posedge core_clk) disable iff (!rst_n)
    comp_on && $past(comp_on) |-> pad_out[1] == ~pad_out[0])
    else $error("Complement cell not inverted");

  AST_GEAR_POP: assert property (@(posedge core_clk) disable iff (!rst_n)
    (out_mode == io_pkg::MODE_GEAR) && ec_rise && head_valid && s_ff.phase == '0 |-> pop ##1 s_ff.phase == 2'h1)
    else $error("Gearbox word not taken");

  AST_OE_FOLLOW: assert property (@(posedge core_clk) disable iff (!rst_n)
    ec_rise && !comp_on |=> pad_tristate_control == $past(oe_req))
    else $error("Tristate control not registered");

  AST_SHIFT_ON: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_ff.cnt == phase_at(s_ff.period, io_pkg::PHASE_DEG) |=> strobe_transfer_delay)
    else $error("Shifted clock not raised at quarter period");
endmodule

// ==== mem_strobe_model.sv ====
module mem_strobe_model #(
  parameter int BEATS = 4
) (
  input  wire logic       go,
  input  wire logic [1:0] beat_data,
  output logic            strobe,
  output logic      [1:0] dq
);
  timeunit 1ns;
  timeprecision 1ns;

  ////////////////////////////////////////////////////////////////
  // Idle: strobe pulled high by termination, data released
  initial begin
    strobe = 1'b1;
    dq = 2'h3;
    forever begin
      @(posedge go);
      #130 strobe = 1'b0;
      dq = beat_data;
      #400;
      for (int i = 0; i < 2 * BEATS; i++) begin
        strobe = ~strobe;
        #200;
      end
      // Release strobe first, data later, so the closing rise sees burst data
      strobe = 1'b1;
      #200 dq = ~beat_data;
    end
  end
endmodule

// ==== testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int PER = 8;

  logic       core_clk;
  logic       rst_n;
  logic [1:0] out_mode;
  logic       sdr_latch;
  logic       diff_pair;
  logic [3:0] in_data;
  logic       in_valid;
  logic       in_ready;
  logic [1:0] oe_req;
  logic       edge_clock_one;
  logic [1:0] pad_out;
  logic [1:0] pad_tristate_control;
  logic [1:0] pad_in;
  logic [1:0] cell_in;
  logic       read_start;
  logic       read_end;
  logic       strobe_in;
  logic       sync_clock_polarity;
  logic       read_active;
  logic [1:0] rd_data;
  logic       rd_valid;
  logic       strobe_transfer_delay;
  logic       go;
  logic       pol;
  int         errors;
  int         checks;
  int         n;

  io_cell_pair DUT (
    .core_clk(core_clk), .rst_n(rst_n), .out_mode(out_mode), .sdr_latch(sdr_latch),
    .diff_pair(diff_pair), .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready),
    .oe_req(oe_req), .edge_clock_one(edge_clock_one), .pad_out(pad_out),
    .pad_tristate_control(pad_tristate_control), .pad_in(pad_in), .cell_in(cell_in),
    .read_start(read_start), .read_end(read_end), .strobe_in(strobe_in),
    .sync_clock_polarity(sync_clock_polarity), .read_active(read_active), .rd_data(rd_data),
    .rd_valid(rd_valid), .strobe_transfer_delay(strobe_transfer_delay)
  );

  mem_strobe_model partner (.go(go), .beat_data(2'h2), .strobe(strobe_in), .dq(pad_in));

  ////////////////////////////////////////////////////////////////
  // Clocks: core 40 ns, edge clock 320 ns with its own phase
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial begin
    edge_clock_one = 1'b0;
    #7;
    forever #160 edge_clock_one = ~edge_clock_one;
  end

  ////////////////////////////////////////////////////////////////
  // Access tasks
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  function automatic logic [7:0] probe(input int sel);
    case (sel)
      0: return {6'h0, pad_out};
      1: return {6'h0, pad_tristate_control};
      2: return {6'h0, cell_in};
      3: return {7'h0, read_active};
      4: return {7'h0, in_ready};
      default: return {7'h0, strobe_transfer_delay};
    endcase
  endfunction

  task automatic wait_for(input int sel, input logic [7:0] exp, input int bound);
    int i;
    i = 0;
    while (probe(sel) !== exp && i < bound) begin
      tick(1);
      i++;
    end
    chk(probe(sel), exp);
    if (probe(sel) !== exp) tally_and_finish();
  endtask

  task automatic push(input logic [3:0] w);
    in_data = w;
    in_valid = 1'b1;
    wait_for(4, 8'h1, 400);
    tick(1);
    in_valid = 1'b0;
    tick(1);
  endtask

  task automatic pulse_read(input logic fin);
    if (fin) read_end = 1'b1;
    else read_start = 1'b1;
    tick(1);
    if (fin) read_end = 1'b0;
    else read_start = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    errors = 0;
    checks = 0;
    rst_n = 1'b0;
    out_mode = 2'h3;
    sdr_latch = 1'b0;
    diff_pair = 1'b0;
    in_data = 4'h0;
    in_valid = 1'b0;
    oe_req = 2'h0;
    read_start = 1'b0;
    read_end = 1'b0;
    go = 1'b0;
    tick(11);
    chk({pad_out, pad_tristate_control, sync_clock_polarity, read_active, in_ready, rd_valid}, 8'h02);
    tick(1);
    rst_n = 1'b1;
    $display("test reset done");

    out_mode = io_pkg::MODE_SDR;
    push(4'h5);
    wait_for(0, 8'h3, 40);
    push(4'ha);
    wait_for(0, 8'h0, 40);
    sdr_latch = 1'b1;
    push(4'h1);
    wait_for(0, 8'h1, 40);
    $display("test single rate done");

    out_mode = io_pkg::MODE_DDR;
    push(4'h6);
    wait_for(0, 8'h2, 40);
    wait_for(0, 8'h1, 6);
    $display("test double rate done");

    out_mode = io_pkg::MODE_GEAR;
    diff_pair = 1'b1;
    oe_req = 2'h1;
    push(4'ha);
    wait_for(0, 8'h2, 40);
    wait_for(0, 8'h1, 6);
    wait_for(0, 8'h2, 6);
    wait_for(0, 8'h1, 6);
    wait_for(1, 8'h3, 20);
    $display("test gearbox done");

    out_mode = io_pkg::MODE_SDR;
    diff_pair = 1'b0;
    oe_req = 2'h2;
    wait_for(1, 8'h2, 20);
    wait_for(2, 8'h3, 10);
    out_mode = 2'h3;
    for (int i = 0; i < 16; i++) push(i[3:0]);
    in_valid = 1'b1;
    tick(3);
    chk({7'h0, in_ready}, 8'h0);
    in_valid = 1'b0;
    out_mode = io_pkg::MODE_SDR;
    wait_for(4, 8'h1, 400);
    $display("test buffer done");

    pulse_read(1'b0);
    go = 1'b1;
    wait_for(3, 8'h1, 60);
    pol = sync_clock_polarity;
    n = 0;
    for (int i = 0; i < 50; i++) begin
      chk({7'h0, sync_clock_polarity}, {7'h0, pol});
      if (rd_valid === 1'b1) begin
        chk({6'h0, rd_data}, 8'h2);
        n++;
      end
      tick(1);
    end
    chk(8'(n > 0), 8'h1);
    pulse_read(1'b1);
    wait_for(3, 8'h0, 5);
    go = 1'b0;
    pulse_read(1'b0);
    tick(2);
    pulse_read(1'b1);
    go = 1'b1;
    for (int i = 0; i < 40; i++) begin
      chk({7'h0, read_active}, 8'h0);
      tick(1);
    end
    $display("test read done");

    wait_for(5, 8'h0, 20);
    wait_for(5, 8'h1, 20);
    n = 0;
    while (strobe_transfer_delay === 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    chk(8'(n), 8'(PER * (io_pkg::FULL_DEG - io_pkg::PHASE_DEG) / io_pkg::FULL_DEG
                  - PER * io_pkg::PHASE_DEG / io_pkg::FULL_DEG));
    $display("test delay done");
    tally_and_finish();
  end
endmodule
